// ### and_bitclear_branch_exec.sv
// Execution core for AND-with-file, bit clear and two branches
`timescale 1ns/1ps
`include "abx_params.svh"
module and_bitclear_branch_exec #(
  parameter int PC_W = 21,
  parameter int MEM_WORDS = 16
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             busy
);
  import abx_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  // Programmer-visible state
  logic            extEnable_r;
  logic [11:0]     indexBase_r;
  logic [15:0]     instr_r;
  logic [7:0]      work_r;
  logic [7:0]      status_r;
  logic [3:0]      bank_r;
  logic [PC_W-1:0] pc_r;
  logic [11:0]     fileAddr_r;
  logic [7:0]      fileMem_r [MEM_WORDS];

  // Execution state
  phase_t          phase_r;
  logic            running_r;
  logic            nopCycle_r;
  logic [7:0]      operand_r;
  logic [7:0]      result_r;
  logic            takeBranch_r;
  logic [AW-1:0]   memIdx_r;
  logic [AW-1:0]   memIdx;

  // Bus state
  logic            awHeld_r;
  logic            wHeld_r;
  logic [31:0]     awAddr_r;
  logic [31:0]     wData_r;
  logic [3:0]      wStrb_r;
  logic            doWrite;
  logic            swWrite;
  logic            startReq;
  logic            pcLoHit;
  logic            pcHiHit;

  op_t             opKind;
  logic            destFile;
  logic [2:0]      bitIndex;
  logic [7:0]      offset;
  logic [11:0]     dataAddr;
  logic [PC_W-1:0] target;

  abx_decode u_decode (
    .instr      (instr_r),
    .bankSelect (bank_r),
    .extEnable  (extEnable_r),
    .indexBase  (indexBase_r),
    .opKind     (opKind),
    .destFile   (destFile),
    .bitIndex   (bitIndex),
    .offset     (offset),
    .dataAddr   (dataAddr),
    .indexedMode()
  );

  abx_branch #(
    .PC_W (PC_W)
  ) u_branch (
    .branchPc (pc_r),
    .offset   (offset),
    .target   (target)
  );

  assign memIdx = dataAddr[AW-1:0];
  assign busy   = running_r;

  // Write channel: address and data taken independently
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign swWrite       = doWrite && !running_r && wStrb_r[0];
  assign startReq      = doWrite && awAddr_r == `ABX_OFF_EXEC &&
                         wStrb_r[0] && wData_r[0];
  assign pcLoHit       = doWrite && awAddr_r == `ABX_OFF_PCLO;
  assign pcHiHit       = doWrite && awAddr_r == `ABX_OFF_PCHI;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 32'h0000_0000;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_r > `ABX_OFF_EXEC) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software registers; writes land only while the core is idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extEnable_r <= `ABX_RST_CTRL;
      indexBase_r <= 12'h000;
    end else if (swWrite && awAddr_r == `ABX_OFF_CTRL) begin
      extEnable_r <= wData_r[0];
      indexBase_r <= wData_r[27:16];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instr_r <= 16'h0000;
    end else if (swWrite && awAddr_r == `ABX_OFF_INSTR) begin
      instr_r <= wData_r[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank_r <= `ABX_RST_BANK;
    end else if (swWrite && awAddr_r == `ABX_OFF_BANK) begin
      bank_r <= wData_r[3:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fileAddr_r <= 12'h000;
    end else if (swWrite && awAddr_r == `ABX_OFF_FADDR) begin
      fileAddr_r <= wData_r[11:0];
    end
  end

  // Four phases per cycle; a taken branch adds one no-operation cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r    <= PH_DECODE;
      running_r  <= 1'b0;
      nopCycle_r <= 1'b0;
    end else if (!running_r) begin
      phase_r <= PH_DECODE;
      if (startReq) begin
        running_r <= 1'b1;
      end
    end else begin
      case (phase_r)
        PH_DECODE:  phase_r <= PH_READ;
        PH_READ:    phase_r <= PH_PROCESS;
        PH_PROCESS: phase_r <= PH_WRITE;
        PH_WRITE: begin
          phase_r <= PH_DECODE;
          if (takeBranch_r && !nopCycle_r) begin
            nopCycle_r <= 1'b1;
          end else begin
            nopCycle_r <= 1'b0;
            running_r  <= 1'b0;
          end
        end
        default: phase_r <= PH_DECODE;
      endcase
    end
  end

  // Operand read and processing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operand_r    <= 8'h00;
      result_r     <= 8'h00;
      takeBranch_r <= 1'b0;
      memIdx_r     <= '0;
    end else if (running_r && !nopCycle_r) begin
      if (phase_r == PH_DECODE) begin
        memIdx_r     <= memIdx;
        takeBranch_r <= 1'b0;
      end
      if (phase_r == PH_READ) begin
        operand_r <= fileMem_r[memIdx_r];
      end
      if (phase_r == PH_PROCESS) begin
        case (opKind)
          OP_AND_WORK_WITH_FILE: result_r <= work_r & operand_r;
          OP_CLEAR_FILE_BIT:
            result_r <= operand_r & ~(8'h01 << bitIndex);
          OP_BRANCH_ON_CARRY_SET:
            takeBranch_r <= status_r[`ABX_STAT_CARRY_BIT];
          OP_BRANCH_ON_NEGATIVE_SET:
            takeBranch_r <= status_r[`ABX_STAT_NEG_BIT];
          default: result_r <= operand_r;
        endcase
      end
    end
  end

  logic writePhase;
  assign writePhase = running_r && !nopCycle_r && phase_r == PH_WRITE;

  // Working register and flags; only the AND and a software STATUS write touch N and Z
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      work_r   <= `ABX_RST_WORK;
      status_r <= `ABX_RST_STATUS;
    end else if (writePhase && opKind == OP_AND_WORK_WITH_FILE) begin
      if (!destFile) begin
        work_r <= result_r;
      end
      status_r[`ABX_STAT_NEG_BIT]  <= result_r[7];
      status_r[`ABX_STAT_ZERO_BIT] <= (result_r == 8'h00);
    end else if (doWrite && !running_r && wStrb_r[0]) begin
      if (awAddr_r == `ABX_OFF_WORK) begin
        work_r <= wData_r[7:0];
      end
      if (awAddr_r == `ABX_OFF_STATUS) begin
        status_r <= wData_r[7:0];
      end
    end
  end

  // Program counter: the taken write happens in the first cycle's last phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_r <= `ABX_RST_PC;
    end else if (writePhase && takeBranch_r) begin
      pc_r <= target;
    end else if (writePhase && opKind != OP_NONE) begin
      pc_r <= pc_r + `ABX_PC_STEP;
    end else if (pcLoHit && !running_r) begin
      pc_r[15:0] <= wData_r[15:0];
    end else if (pcHiHit && !running_r) begin
      pc_r[PC_W-1:16] <= wData_r[PC_W-17:0];
    end
  end

  // File storage, one entry per index
  genvar gi;
  generate
    for (gi = 0; gi < MEM_WORDS; gi++) begin : g_mem
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          fileMem_r[gi] <= 8'h00;
        end else if (writePhase && memIdx_r == AW'(gi) &&
                     (opKind == OP_CLEAR_FILE_BIT ||
                      (opKind == OP_AND_WORK_WITH_FILE && destFile))) begin
          fileMem_r[gi] <= result_r;
        end else if (doWrite && !running_r && wStrb_r[0] &&
                     awAddr_r == `ABX_OFF_FDATA &&
                     fileAddr_r[AW-1:0] == AW'(gi)) begin
          fileMem_r[gi] <= wData_r[7:0];
        end
      end
    end
  endgenerate

  // Read channel, one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `ABX_OFF_CTRL:
          s_axi_rdata <= {4'h0, indexBase_r, 15'h0000, extEnable_r};
        `ABX_OFF_INSTR: s_axi_rdata <= {16'h0000, instr_r};
        `ABX_OFF_WORK: s_axi_rdata <= {24'h000000, work_r};
        `ABX_OFF_STATUS: s_axi_rdata <= {24'h000000, status_r};
        `ABX_OFF_BANK: s_axi_rdata <= {28'h0000000, bank_r};
        `ABX_OFF_PCLO: s_axi_rdata <= {16'h0000, pc_r[15:0]};
        `ABX_OFF_PCHI: s_axi_rdata <= 32'(pc_r[PC_W-1:16]);
        `ABX_OFF_FADDR: s_axi_rdata <= {20'h00000, fileAddr_r};
        `ABX_OFF_FDATA:
          s_axi_rdata <= {24'h000000, fileMem_r[fileAddr_r[AW-1:0]]};
        `ABX_OFF_EXEC: s_axi_rdata <= {31'h00000000, running_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### abx_params.svh
// Constants for the bit-clear, AND and branch execution block
`ifndef ABX_PARAMS_SVH
`define ABX_PARAMS_SVH

`define ABX_OFF_CTRL      32'h0000_0000
`define ABX_OFF_INSTR     32'h0000_0004
`define ABX_OFF_WORK      32'h0000_0008
`define ABX_OFF_STATUS    32'h0000_000c
`define ABX_OFF_BANK      32'h0000_0010
`define ABX_OFF_PCLO      32'h0000_0014
`define ABX_OFF_PCHI      32'h0000_0018
`define ABX_OFF_FADDR     32'h0000_001c
`define ABX_OFF_FDATA     32'h0000_0020
`define ABX_OFF_EXEC      32'h0000_0024

`define ABX_OP_AND_HI     6'h05
`define ABX_OP_CLR_HI     4'h9
`define ABX_OP_BC         8'he2
`define ABX_OP_BN         8'he6
`define ABX_INDEX_LIMIT   8'h5f
`define ABX_ACCESS_SPLIT  8'h60
`define ABX_ACCESS_HIBANK 4'hf

`define ABX_STAT_NEG_BIT  4
`define ABX_STAT_ZERO_BIT 2
`define ABX_STAT_CARRY_BIT 0

`define ABX_RST_WORK      8'h00
`define ABX_RST_STATUS    8'h00
`define ABX_RST_BANK      4'h0
`define ABX_RST_PC        21'h000000
`define ABX_RST_CTRL      1'b0
`define ABX_PC_STEP       21'h000002
`define ABX_NUM_PHASES    4

`endif

// ### abx_pkg.sv
// Types shared by the execution block and its helpers
package abx_pkg;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_AND_WORK_WITH_FILE,
    OP_CLEAR_FILE_BIT,
    OP_BRANCH_ON_CARRY_SET,
    OP_BRANCH_ON_NEGATIVE_SET
  } op_t;

endpackage

// ### abx_decode.sv
// Opcode field extraction and data address formation
`timescale 1ns/1ps
`include "abx_params.svh"
module abx_decode (
  input  wire logic [15:0]     instr,
  input  wire logic [3:0]      bankSelect,
  input  wire logic            extEnable,
  input  wire logic [11:0]     indexBase,
  output abx_pkg::op_t         opKind,
  output logic                 destFile,
  output logic [2:0]           bitIndex,
  output logic [7:0]           offset,
  output logic [11:0]          dataAddr,
  output logic                 indexedMode
);
  import abx_pkg::*;

  logic       accessBit;
  logic [7:0] fileAddr;

  assign fileAddr  = instr[7:0];
  assign offset    = instr[7:0];
  assign bitIndex  = instr[11:9];
  assign destFile  = instr[9];
  assign accessBit = (instr[15:12] == `ABX_OP_CLR_HI) ? instr[8] : instr[8];

  always_comb begin
    if (instr[15:10] == `ABX_OP_AND_HI) begin
      opKind = OP_AND_WORK_WITH_FILE;
    end else if (instr[15:12] == `ABX_OP_CLR_HI) begin
      opKind = OP_CLEAR_FILE_BIT;
    end else if (instr[15:8] == `ABX_OP_BC) begin
      opKind = OP_BRANCH_ON_CARRY_SET;
    end else if (instr[15:8] == `ABX_OP_BN) begin
      opKind = OP_BRANCH_ON_NEGATIVE_SET;
    end else begin
      opKind = OP_NONE;
    end
  end

  // Access bank: low part maps to bank 0, or to indexBase plus the address when extEnable is set; high part to the top bank
  always_comb begin
    indexedMode = !accessBit && extEnable &&
                  (fileAddr <= `ABX_INDEX_LIMIT);
    if (indexedMode) begin
      dataAddr = indexBase + {4'h0, fileAddr};
    end else if (accessBit) begin
      dataAddr = {bankSelect, fileAddr};
    end else if (fileAddr < `ABX_ACCESS_SPLIT) begin
      dataAddr = {4'h0, fileAddr};
    end else begin
      dataAddr = {`ABX_ACCESS_HIBANK, fileAddr};
    end
  end
endmodule

// ### abx_branch.sv
// Relative branch target arithmetic
`timescale 1ns/1ps
`include "abx_params.svh"
module abx_branch #(
  parameter int PC_W = 21
) (
  input  wire logic [PC_W-1:0] branchPc,
  input  wire logic [7:0]      offset,
  output logic [PC_W-1:0]      target
);
  logic [PC_W-1:0] extOffset;

  // Signed offset doubled, added to the counter plus one step
  assign extOffset = {{(PC_W-9){offset[7]}}, offset, 1'b0};
  assign target = branchPc + `ABX_PC_STEP + extOffset;
endmodule

// ### abx_exec_properties.sv
// Bus and execution timing checks for the execution block
`timescale 1ns/1ps
`include "abx_params.svh"
module abx_exec_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wrGo;
  logic arGo;
  // Only writes offered on both channels at once count as a start
  assign wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign arGo = s_axi_arvalid && s_axi_arready;
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
  read_answer_a: assert property (arGo |=> s_axi_rvalid)
    else $error("no read answer");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while answering");
  // Both channels are held one edge before the response is launched
  write_answer_a: assert property (wrGo |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  read_range_a: assert property (arGo |=> s_axi_rresp ==
    ($past(s_axi_araddr) > `ABX_OFF_EXEC || $past(s_axi_araddr[1:0]) != 2'h0
    ? 2'h2 : 2'h0)) else $error("bad rresp");
  write_range_a: assert property (wrGo |-> ##2 s_axi_bresp ==
    ($past(s_axi_awaddr, 2) > `ABX_OFF_EXEC ? 2'h2 : 2'h0))
    else $error("bad bresp");
  exec_start_a: assert property (wrGo && s_axi_awaddr == `ABX_OFF_EXEC
    && s_axi_wdata[0] && s_axi_wstrb[0] && !busy |-> ##[1:2] busy)
    else $error("start ignored");
  busy_len_a: assert property ($rose(busy) |-> busy[*4] ##1
    ((!busy) or (busy[*4] ##1 !busy))) else $error("bad busy length");
  cover property ($rose(busy) ##8 !busy);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind and_bitclear_branch_exec abx_exec_checker i_abx_exec_checker (
  .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);

// ### axi_lite_host.sv
// Register bus master standing in for software
`timescale 1ns/1ps
module axi_lite_host (
  input  wire logic        clk,
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [31:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // Taken payloads are inverted so stale values cannot pass for good ones
  task automatic wr(input logic [31:0] a, d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### and_bitclear_branch_exec_tb.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "abx_params.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module and_bitclear_branch_exec_tb;
  logic        clk, nrst, busy;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          failures, checksDone, cycles, busyLen;
  logic [18:0] notes[$];
  logic [18:0] note;
  logic [7:0]  wv, fv, st, ex;
  logic [7:0]  offs[4];
  logic [20:0] tgt;
  and_bitclear_branch_exec i_and_bitclear_branch_exec (
    .clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);
  axi_lite_host i_axi_lite_host (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watcher: each answer takes the oldest note; bit 18 means data ignored
  always @(posedge clk) begin
    cycles++;
    if (busy === 1'b1) busyLen++;
    if (cycles == 8000) begin
      failures++;
      report_and_stop();
    end else if ((s_axi_bvalid && s_axi_bready) ||
                 (s_axi_rvalid && s_axi_rready)) begin
      note = notes.pop_front();
      if (s_axi_bvalid) `CHK(s_axi_bresp, note[17:16])
      else `CHK({s_axi_rresp, note[18] ? note[15:0] : s_axi_rdata[15:0]},
        note[17:0])
    end
  end
  task automatic wrReg(input logic [31:0] a, d, input logic [1:0] r = 2'h0);
    notes.push_back({1'b0, r, 16'h0});
    i_axi_lite_host.wr(a, d);
  endtask
  task automatic expReg(input logic [31:0] a, input logic [15:0] d,
      input logic [1:0] r = 2'h0);
    notes.push_back({r != 2'h0, r, d});
    i_axi_lite_host.rd(a);
  endtask
  task automatic setFile(input logic [7:0] f, v);
    wrReg(`ABX_OFF_FADDR, {24'h0, f});
    wrReg(`ABX_OFF_FDATA, {24'h0, v});
  endtask
  task automatic expFile(input logic [7:0] f, v);
    wrReg(`ABX_OFF_FADDR, {24'h0, f});
    expReg(`ABX_OFF_FDATA, {8'h0, v});
  endtask
  task automatic expPc(input logic [20:0] v);
    expReg(`ABX_OFF_PCLO, v[15:0]);
    expReg(`ABX_OFF_PCHI, {11'h0, v[20:16]});
  endtask
  task automatic run(input logic [15:0] ins, input int len);
    wrReg(`ABX_OFF_INSTR, {16'h0, ins});
    busyLen = 0;
    wrReg(`ABX_OFF_EXEC, 32'h1);
    repeat (2) @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    `CHK(busyLen, len)
  endtask
  initial begin
    nrst = 1'b0;
    {failures, checksDone, cycles, busyLen} = '0;
    void'($urandom(32'hf015a4fe));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    expReg(`ABX_OFF_WORK, 16'h0);
    expReg(`ABX_OFF_STATUS, 16'h0);
    expPc(21'h0);
    expReg(`ABX_OFF_CTRL, 16'h0);
    expReg(`ABX_OFF_BANK, 16'h0);
    expReg(`ABX_OFF_EXEC, 16'h0);
    expReg(32'h28, 16'h0, 2'h2);
    wrReg(32'h40, 32'h0, 2'h2);
    $display("reset and map test done");
    wv = 8'($urandom);
    fv = 8'($urandom);
    st = 8'($urandom);
    wrReg(`ABX_OFF_WORK, {24'h0, wv});
    wrReg(`ABX_OFF_STATUS, {24'h0, st});
    setFile(8'h03, fv);
    run({`ABX_OP_AND_HI, 2'b00, 8'h03}, 4);
    ex = wv & fv;
    st = (st & 8'heb) | {3'h0, ex[7], 1'b0, ex == 8'h0, 2'h0};
    expReg(`ABX_OFF_WORK, {8'h0, ex});
    expFile(8'h03, fv);
    expReg(`ABX_OFF_STATUS, {8'h0, st});
    expPc(21'h2);
    // Complement in W forces a zero result written back to the file
    wrReg(`ABX_OFF_BANK, 32'h3);
    wrReg(`ABX_OFF_WORK, {24'h0, ~fv});
    setFile(8'h17, fv);
    run({`ABX_OP_AND_HI, 2'b11, 8'h17}, 4);
    st = (st & 8'heb) | 8'h04;
    expFile(8'h17, 8'h0);
    expReg(`ABX_OFF_WORK, {8'h0, ~fv});
    expReg(`ABX_OFF_STATUS, {8'h0, st});
    expReg(`ABX_OFF_BANK, 16'h3);
    expReg(`ABX_OFF_INSTR, {`ABX_OP_AND_HI, 2'b11, 8'h17});
    $display("and test done");
    for (int b = 0; b < 8; b++) begin
      fv = 8'($urandom) | (8'h1 << b);
      setFile(8'h05, fv);
      run({`ABX_OP_CLR_HI, 3'(b), 1'b0, 8'h05}, 4);
      expFile(8'h05, fv & ~(8'h1 << b));
    end
    expReg(`ABX_OFF_STATUS, {8'h0, st});
    // Base 7: indexed f=2 lands on word 9, f=0x60 stays in the access bank
    wrReg(`ABX_OFF_CTRL, 32'h0007_0001);
    expReg(`ABX_OFF_CTRL, 16'h0001);
    setFile(8'h09, 8'hff);
    setFile(8'h02, 8'hff);
    setFile(8'h00, 8'hff);
    setFile(8'h07, 8'hff);
    run({`ABX_OP_CLR_HI, 3'h0, 1'b0, 8'h02}, 4);
    run({`ABX_OP_CLR_HI, 3'h1, 1'b0, 8'h60}, 4);
    expFile(8'h09, 8'hfe);
    expFile(8'h02, 8'hff);
    expFile(8'h00, 8'hfd);
    expFile(8'h07, 8'hff);
    wrReg(`ABX_OFF_CTRL, 32'h0);
    $display("bit clear test done");
    offs = '{8'h05, 8'h80, 8'h7f, 8'($urandom)};
    foreach (offs[i]) for (int k = 0; k < 4; k++) begin
      st = 8'($urandom);
      st[k[1] ? 4 : 0] = k[0];
      wrReg(`ABX_OFF_PCLO, 32'h0);
      wrReg(`ABX_OFF_PCHI, 32'h1);
      wrReg(`ABX_OFF_STATUS, {24'h0, st});
      tgt = 21'h10002 + (k[0] ? {{12{offs[i][7]}}, offs[i], 1'b0} : 21'h0);
      run({k[1] ? `ABX_OP_BN : `ABX_OP_BC, offs[i]}, k[0] ? 8 : 4);
      expPc(tgt);
      expReg(`ABX_OFF_STATUS, {8'h0, st});
    end
    // An undecoded word runs one cycle and leaves the counter alone
    run(16'hffff, 4);
    expPc(tgt);
    $display("branch test done");
    report_and_stop();
  end
endmodule
